// ### dv/alloc_sink.sv
// link engine stand-in draining the allocation stream
`timescale 1ns/1ps
`default_nettype none
module alloc_sink (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // stall control
    input wire logic slow,
    // allocation stream
    output logic alloc_ready
);
    logic [2:0] tick_ff;
    // slow takes one beat in eight so the buffer fills and refuses
    always_ff @(posedge sys_clk)
    begin
        tick_ff <= rstn ? tick_ff + 3'h1 : 3'h0;
        alloc_ready <= rstn && (!slow || tick_ff == 3'h7);
    end
endmodule : alloc_sink
`default_nettype wire

// ### dv/link_alloc_checker.sv
// port assertions for the link area allocator
`timescale 1ns/1ps
`default_nettype none
module link_alloc_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // observed ports
    input wire logic [15:0] setup_rdata,
    input wire logic links_running,
    input wire logic config_error,
    input wire logic [1:0] active_mode,
    input wire logic table_valid,
    input wire logic table_ready,
    input wire logic [5:0] table_node,
    input wire logic backup_wr,
    input wire logic alloc_valid,
    input wire logic alloc_ready,
    input wire logic [link_alloc_pkg::ENTRY_W-1:0] alloc_entry,
    input wire logic legacy_valid,
    input wire logic legacy_relay,
    input wire logic [6:0] legacy_word,
    input wire logic mapped_valid,
    input wire logic mapped_mem,
    input wire logic [15:0] mapped_word,
    input wire logic mapped_error
);
    import link_alloc_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    stop_clear_a: assert property (
        links_running && !setup_rdata[START_BIT] |=> !links_running)
        else $error("links kept running after stop");
    relay_map_a: assert property (
        legacy_valid && legacy_relay && legacy_word <= 7'h3F |=> mapped_valid && !mapped_mem
        && !mapped_error && mapped_word == CORE_IO_BASE + {9'h000, $past(legacy_word)})
        else $error("relay word mapped wrongly");
    mem_map_a: assert property (
        legacy_valid && !legacy_relay
        |=> mapped_valid && mapped_mem && mapped_word == {9'h000, $past(legacy_word)})
        else $error("memory word mapped wrongly");
    relay_err_a: assert property (
        legacy_valid && legacy_relay && legacy_word > 7'h3F |=> mapped_valid && mapped_error)
        else $error("relay word out of range not flagged");
    alloc_hold_a: assert property (
        alloc_valid && !alloc_ready |=> alloc_valid && $stable(alloc_entry))
        else $error("allocation entry dropped under stall");
    auto_equal_a: assert property (
        alloc_valid && active_mode != 2'h0 |-> alloc_entry[47:40] == alloc_entry[39:32]
        && alloc_entry[15:8] == alloc_entry[7:0])
        else $error("automatic counts differ");
    io_window_a: assert property (
        alloc_valid && active_mode[0] |-> alloc_entry[63:48] >= CORE_IO_BASE
        && alloc_entry[63:48] + {8'h00, alloc_entry[47:40]} <= CORE_IO_LAST + 16'h0001)
        else $error("io block outside window");
    err_norun_a: assert property (config_error |-> !links_running)
        else $error("running with rejected table");
    backup_take_a: assert property (
        table_valid && table_ready && table_node != 6'h00 |=> backup_wr && !table_ready)
        else $error("table entry not backed up");
endmodule : link_alloc_checker
bind link_area_config_allocator link_alloc_checker u_chk (.sys_clk, .rstn, .setup_rdata,
    .links_running, .config_error, .active_mode, .table_valid, .table_ready, .table_node,
    .backup_wr, .alloc_valid, .alloc_ready, .alloc_entry, .legacy_valid, .legacy_relay,
    .legacy_word, .mapped_valid, .mapped_mem, .mapped_word, .mapped_error);
`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the link area allocator
`timescale 1ns/1ps
`default_nettype none
module tb;
    import link_alloc_pkg::*;
    logic sys_clk = 1'h0, rstn = 1'h0, setup_wr = 1'h0, startup_node = 1'h1, slow = 1'h0;
    logic table_valid = 1'h0, table_last = 1'h0, legacy_valid = 1'h0, legacy_relay = 1'h0;
    logic [15:0] setup_wdata = 16'h0000, setup_init = 16'h0031, peer_setup_word = 16'h0000;
    logic [6:0] legacy_word = 7'h00;
    logic [ENTRY_W-1:0] tab = '0, backup_entry, alloc_entry, exp_q[$], bk_q[$], mtab[3];
    logic [15:0] setup_rdata, mapped_word, w;
    logic links_running, config_error, table_ready, backup_wr, alloc_valid, alloc_ready;
    logic mapped_valid, mapped_mem, mapped_error;
    logic [1:0] active_mode;
    logic [5:0] backup_index;
    int err_total = 0, checks_done = 0, seed = 90961, n, bk_n = 0;
    initial forever #2.5 sys_clk = ~sys_clk;
    link_area_config_allocator u_dut (.sys_clk, .rstn, .setup_wr, .setup_wdata, .setup_init,
        .setup_rdata, .links_running, .config_error, .active_mode, .startup_node,
        .peer_setup_word, .table_valid, .table_ready, .table_node(tab[69:64]),
        .table_io_start(tab[63:48]), .table_io_send(tab[47:40]), .table_io_recv(tab[39:32]),
        .table_mem_start(tab[31:16]), .table_mem_send(tab[15:8]), .table_mem_recv(tab[7:0]),
        .table_last, .backup_wr, .backup_index, .backup_entry, .alloc_valid, .alloc_ready,
        .alloc_entry, .legacy_valid, .legacy_relay, .legacy_word, .mapped_valid, .mapped_mem,
        .mapped_word, .mapped_error);
    alloc_sink u_sink (.sys_clk, .rstn, .slow, .alloc_ready);
    function automatic logic [ENTRY_W-1:0] auto_ent(input logic [15:0] m, input int i);
        logic [7:0] iw, mw;
        iw = m[4] ? 8'h04 << m[7:6] : 8'h00;
        mw = m[5] ? 8'h08 << m[7:6] : 8'h00;
        return {6'(i + 1), m[4] ? 16'(16'h03E8 + i * iw) : 16'h0000, iw, iw,
            m[5] ? 16'(i * mw) : 16'h0000, mw, mw};
    endfunction : auto_ent
    task automatic check(input logic [ENTRY_W-1:0] seen, input logic [ENTRY_W-1:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    task automatic wr(input logic [15:0] d);
        setup_wr <= 1'h1;
        setup_wdata <= d;
        @(posedge sys_clk);
        setup_wr <= 1'h0;
        @(posedge sys_clk);
    endtask : wr
    task automatic wait_run(input logic lvl);
        n = 0;
        while (links_running !== lvl && n < 400)
        begin
            @(posedge sys_clk);
            n++;
        end
        check(links_running, lvl);
    endtask : wait_run
    task automatic run_auto(input logic [15:0] d, input logic [15:0] eff);
        for (int i = 0; i < (16 >> eff[7:6]); i++)
            exp_q.push_back(auto_ent(eff, i));
        wr(d);
        wait_run(1'h1);
        check(active_mode, eff[5:4]);
        check(config_error, 1'h0);
    endtask : run_auto
    task automatic stop(input logic [15:0] d);
        n = 0;
        while (exp_q.size() != 0 && n < 600)
        begin
            @(posedge sys_clk);
            n++;
        end
        check(exp_q.size(), 0);
        wr(d & 16'hFFFE);
        wait_run(1'h0);
    endtask : stop
    task automatic send_tab(input logic [ENTRY_W-1:0] e, input logic last, input logic ok);
        if (ok)
        begin
            exp_q.push_back(e);
            bk_q.push_back(e);
        end
        table_valid <= 1'h1;
        tab <= e;
        table_last <= last;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (table_ready !== 1'h1 && n < 200);
        // idle edge so valid never drops and rises in one step
        table_valid <= 1'h0;
        @(posedge sys_clk);
    endtask : send_tab
    always @(posedge sys_clk)
    begin
        if (rstn && alloc_valid === 1'h1 && alloc_ready === 1'h1)
            check(alloc_entry, exp_q.pop_front());
        if (rstn && backup_wr === 1'h1)
        begin
            check(backup_entry, bk_q.pop_front());
            check(backup_index, bk_n);
            bk_n++;
        end
    end
    initial
    begin
        #400000;
        err_total++;
        end_sim();
    end
    initial
    begin
        for (int i = 0; i < 16; i++)
            exp_q.push_back(auto_ent(16'h0031, i));
        repeat (2) @(posedge sys_clk);
        rstn <= 1'h1;
        wait_run(1'h1);
        check(setup_rdata, 16'h0031);
        stop(16'h0031);
        for (int m = 1; m < 4; m++)
            for (int s = 0; s < 4; s++)
            begin
                w = (16'($random(seed)) & 16'hFF0E) | 16'(s << 6) | 16'(m << 4);
                slow <= w[8];
                wr(w);
                run_auto(w | 16'h0001, w);
                stop(w);
            end
        run_auto(16'h0031, 16'h0031);
        wr(16'h00D1);
        repeat (20) @(posedge sys_clk);
        check(active_mode, 2'h3);
        stop(16'h0031);
        // manual entries contiguous in each area, last at the node and count limits
        mtab[0] = {6'h01, 16'h0064, 8'h05, 8'h03, 16'h00C8, 8'h0A, 8'h02};
        mtab[1] = {6'h03, 16'h0069, 8'h00, 8'h04, 16'h00D2, 8'h00, 8'h01};
        mtab[2] = {6'h3E, 16'h0069, 8'hFE, 8'h00, 16'h00D2, 8'h04, 8'h06};
        wr(16'h0001);
        for (int i = 0; i < 3; i++)
            send_tab(mtab[i], i == 2, 1'h1);
        wait_run(1'h1);
        check(active_mode, 2'h0);
        stop(16'h0001);
        wr(16'h0001);
        send_tab('0, 1'h1, 1'h0);
        n = 0;
        while (config_error !== 1'h1 && n < 50)
        begin
            @(posedge sys_clk);
            n++;
        end
        check(config_error, 1'h1);
        check(links_running, 1'h0);
        stop(16'h0001);
        startup_node <= 1'h0;
        peer_setup_word <= 16'h0050;
        run_auto(16'h00F1, 16'h0050);
        stop(16'h00F1);
        for (int i = 0; i < 40; i++)
        begin
            legacy_valid <= 1'h1;
            legacy_relay <= ~i[0];
            legacy_word <= i < 2 ? 7'(7'h3F + i) : 7'($random(seed));
            @(posedge sys_clk);
            legacy_valid <= 1'h0;
            @(posedge sys_clk);
            if (legacy_relay && legacy_word > 7'h3F)
                check(mapped_error, 1'h1);
            else
                check(mapped_word, legacy_relay ? 16'h03E8 + legacy_word : legacy_word);
        end
        end_sim();
    end
endmodule : tb
`default_nettype wire

// ### logic/auto_range_calc.sv
// per-node word ranges for automatic allocation
`timescale 1ns/1ps
`default_nettype none
module auto_range_calc (
    // selection
    input wire logic [1:0] size_code,
    input wire logic [3:0] node_idx,
    // derived ranges
    output logic [7:0] io_words,
    output logic [7:0] mem_words,
    output logic [4:0] node_count,
    output logic [15:0] io_start,
    output logic [15:0] mem_start
);
    import link_alloc_pkg::*;

    // blocks packed back to back from the area base
    always_comb
    begin
        io_words = IO_WORDS_MIN << size_code;
        mem_words = MEM_WORDS_MIN << size_code;
        node_count = AUTO_NODES_MAX >> size_code;
        io_start = CORE_IO_BASE + 16'(node_idx) * 16'(io_words);
        mem_start = PARAM_MEM_BASE + 16'(node_idx) * 16'(mem_words);
    end
endmodule : auto_range_calc
`default_nettype wire

// ### logic/link_alloc_pkg.sv
// constants, field layout and types shared by the link area allocator
package link_alloc_pkg;

    // setup word field positions
    localparam int START_BIT = 0;
    localparam int MODE_LO_BIT = 4;
    localparam int MODE_HI_BIT = 5;
    localparam int SIZE_LO_BIT = 6;
    localparam int SIZE_HI_BIT = 7;
    localparam logic [15:0] SETUP_RESET = 16'h0000;

    // automatic allocation windows
    localparam logic [15:0] CORE_IO_BASE = 16'h03E8;
    localparam logic [15:0] CORE_IO_LAST = 16'h0427;
    localparam logic [15:0] PARAM_MEM_BASE = 16'h0000;
    localparam logic [15:0] PARAM_MEM_LAST = 16'h007F;
    localparam logic [7:0] IO_WORDS_MIN = 8'h04;
    localparam logic [7:0] MEM_WORDS_MIN = 8'h08;
    localparam logic [4:0] AUTO_NODES_MAX = 5'h10;

    // manual table limits
    localparam logic [5:0] MANUAL_NODES_MAX = 6'h3E;
    localparam logic [7:0] WORDS_PER_NODE_MAX = 8'hFE;

    // legacy map
    localparam logic [6:0] LEGACY_RELAY_LAST = 7'h3F;
    localparam logic [6:0] LEGACY_MEM_LAST = 7'h7F;

    // allocation entry: node, io start, io send, io recv, mem start, mem send, mem recv
    localparam int ENTRY_W = 70;

    typedef enum logic [1:0] {
        MODE_MANUAL,
        MODE_CORE_IO,
        MODE_PARAM_MEM,
        MODE_BOTH
    } link_mode_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_GEN,
        ST_MANUAL,
        ST_RUN,
        ST_ERROR
    } link_state_type;

endpackage : link_alloc_pkg

// ### logic/link_area_config_allocator.sv
// link setup word decode, start/stop control and link area allocation
// Overview of operation
// - Automatic modes 01, 10, 11 in bits 5:4 link core io only, memory only, or both.
// - Bits 5:4 both zero select manual mode with externally supplied tables.
// - Bits 7:6 pick 4/8, 8/16, 16/32 or 32/64 io/memory words per node.
// - Automatic allocation uses io words 1000..1063 and memory words 0..127 in node order.
// - Automatic node count is 16, 8, 4 or 2 by word size, nodes numbered from 1.
// - Automatic mode gives every node the same number of words.
// - Manual tables carry separate send and receive counts for up to 62 nodes.
// - Links start on a rising start bit, or at power-up if the bit is already set.
// - Links stop when the start bit is cleared.
// - Mode and arrangement come from the starting node's setup word only.
// - Invalid table settings keep the links from running; every mode and size code is accepted.
// - Each area's allocation is one contiguous run without gaps between nodes.
// - Manual tables are copied to the backup settings area.
// - Legacy relay words 0..63 map to io 1000..1063, legacy memory 0..127 to 0..127.
// - The start/stop control is bit 0 of the first setup word.
`timescale 1ns/1ps
`default_nettype none
module link_area_config_allocator (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // host setup word
    input wire logic setup_wr,
    input wire logic [15:0] setup_wdata,
    input wire logic [15:0] setup_init,
    output logic [15:0] setup_rdata,
    // status
    output logic links_running,
    output logic config_error,
    output logic [1:0] active_mode,
    // network role
    input wire logic startup_node,
    input wire logic [15:0] peer_setup_word,
    // manual table input
    input wire logic table_valid,
    output logic table_ready,
    input wire logic [5:0] table_node,
    input wire logic [15:0] table_io_start,
    input wire logic [7:0] table_io_send,
    input wire logic [7:0] table_io_recv,
    input wire logic [15:0] table_mem_start,
    input wire logic [7:0] table_mem_send,
    input wire logic [7:0] table_mem_recv,
    input wire logic table_last,
    // table backup
    output logic backup_wr,
    output logic [5:0] backup_index,
    output logic [link_alloc_pkg::ENTRY_W-1:0] backup_entry,
    // allocation stream to the link engine
    output logic alloc_valid,
    input wire logic alloc_ready,
    output logic [link_alloc_pkg::ENTRY_W-1:0] alloc_entry,
    // legacy address map
    input wire logic legacy_valid,
    input wire logic legacy_relay,
    input wire logic [6:0] legacy_word,
    output logic mapped_valid,
    output logic mapped_mem,
    output logic [15:0] mapped_word,
    output logic mapped_error
);
    import link_alloc_pkg::*;

    // host word group
    logic [15:0] setup_ff;
    logic [15:0] nxt_setup;
    logic loaded_ff;
    logic nxt_loaded;
    logic start_prev_ff;
    logic nxt_start_prev;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;

    // control group
    link_state_type state_ff;
    link_state_type nxt_state;
    link_mode_type mode_ff;
    link_mode_type nxt_mode;
    logic [1:0] size_ff;
    logic [1:0] nxt_size;
    logic [3:0] idx_ff;
    logic [3:0] nxt_idx;
    logic [5:0] entries_ff;
    logic [5:0] nxt_entries;
    logic pend_ff;
    logic nxt_pend;
    logic pend_last_ff;
    logic nxt_pend_last;
    logic [ENTRY_W-1:0] pend_entry_ff;
    logic [ENTRY_W-1:0] nxt_pend_entry;
    logic io_seen_ff;
    logic nxt_io_seen;
    logic mem_seen_ff;
    logic nxt_mem_seen;
    logic [15:0] io_exp_ff;
    logic [15:0] nxt_io_exp;
    logic [15:0] mem_exp_ff;
    logic [15:0] nxt_mem_exp;
    logic tready_ff;
    logic nxt_tready;
    logic bwr_ff;
    logic nxt_bwr;
    logic [5:0] bidx_ff;
    logic [5:0] nxt_bidx;
    logic [ENTRY_W-1:0] bentry_ff;
    logic [ENTRY_W-1:0] nxt_bentry;
    logic run_ff;
    logic nxt_run;
    logic err_ff;
    logic nxt_err;

    // legacy map group
    logic map_v_ff;
    logic nxt_map_v;
    logic map_mem_ff;
    logic nxt_map_mem;
    logic [15:0] map_word_ff;
    logic [15:0] nxt_map_word;
    logic map_err_ff;
    logic nxt_map_err;

    // shared signals
    logic start_bit;
    logic start_rise;
    logic [15:0] eff_word;
    logic push;
    logic [ENTRY_W-1:0] push_data;
    logic buf_in_ready;
    logic [7:0] io_words;
    logic [7:0] mem_words;
    logic [4:0] node_count;
    logic [15:0] io_start;
    logic [15:0] mem_start;
    logic use_io;
    logic use_mem;
    logic bad_entry;

    auto_range_calc u_range (
        .size_code(size_ff),
        .node_idx(idx_ff),
        .io_words(io_words),
        .mem_words(mem_words),
        .node_count(node_count),
        .io_start(io_start),
        .mem_start(mem_start)
    );

    two_entry_buffer #(.WIDTH(ENTRY_W)) u_buf (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_valid(push),
        .in_ready(buf_in_ready),
        .in_data(push_data),
        .out_valid(alloc_valid),
        .out_ready(alloc_ready),
        .out_data(alloc_entry)
    );

    assign start_bit = setup_ff[START_BIT];
    assign start_rise = start_bit && !start_prev_ff;

    // host word: the stored image is taken once after release, so a set bit starts the links
    always_comb
    begin
        nxt_setup = setup_ff;
        nxt_loaded = 1'b1;
        if (!loaded_ff)
            nxt_setup = setup_init;
        else if (setup_wr)
            nxt_setup = setup_wdata;
        nxt_start_prev = loaded_ff ? start_bit : 1'b0;
        nxt_rdata = nxt_setup;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            setup_ff <= SETUP_RESET;
            loaded_ff <= 1'b0;
            start_prev_ff <= 1'b0;
            rdata_ff <= SETUP_RESET;
        end
        else
        begin
            setup_ff <= nxt_setup;
            loaded_ff <= nxt_loaded;
            start_prev_ff <= nxt_start_prev;
            rdata_ff <= nxt_rdata;
        end
    end

    // control
    always_comb
    begin
        eff_word = startup_node ? setup_ff : peer_setup_word;
        use_io = (mode_ff == MODE_CORE_IO) || (mode_ff == MODE_BOTH);
        use_mem = (mode_ff == MODE_PARAM_MEM) || (mode_ff == MODE_BOTH);
        nxt_state = state_ff;
        nxt_mode = mode_ff;
        nxt_size = size_ff;
        nxt_idx = idx_ff;
        nxt_entries = entries_ff;
        nxt_pend = pend_ff;
        nxt_pend_last = pend_last_ff;
        nxt_pend_entry = pend_entry_ff;
        nxt_io_seen = io_seen_ff;
        nxt_mem_seen = mem_seen_ff;
        nxt_io_exp = io_exp_ff;
        nxt_mem_exp = mem_exp_ff;
        nxt_bwr = 1'b0;
        nxt_bidx = bidx_ff;
        nxt_bentry = bentry_ff;
        nxt_err = err_ff;
        push = 1'b0;
        push_data = pend_entry_ff;
        // equal send and receive counts, unused area left empty
        if (state_ff == ST_GEN)
        begin
            push = 1'b1;
            // widened before the add so node 16 does not wrap to 0
            push_data = {{2'b00, idx_ff} + 6'h01,
                use_io ? io_start : 16'h0000,
                use_io ? io_words : 8'h00, use_io ? io_words : 8'h00,
                use_mem ? mem_start : 16'h0000,
                use_mem ? mem_words : 8'h00, use_mem ? mem_words : 8'h00};
        end
        else if (state_ff == ST_MANUAL)
            push = pend_ff;
        bad_entry = (table_node == 6'h00) || (table_node > MANUAL_NODES_MAX)
            || (entries_ff == MANUAL_NODES_MAX)
            || (table_io_send > WORDS_PER_NODE_MAX) || (table_io_recv > WORDS_PER_NODE_MAX)
            || (table_mem_send > WORDS_PER_NODE_MAX) || (table_mem_recv > WORDS_PER_NODE_MAX)
            || (io_seen_ff && table_io_send != 8'h00 && table_io_start != io_exp_ff)
            || (mem_seen_ff && table_mem_send != 8'h00 && table_mem_start != mem_exp_ff);
        unique case (state_ff)
            ST_IDLE, ST_RUN, ST_ERROR:
            begin
                if (start_rise)
                begin
                    // fields frozen until the next start
                    nxt_mode = link_mode_type'(eff_word[MODE_HI_BIT:MODE_LO_BIT]);
                    nxt_size = eff_word[SIZE_HI_BIT:SIZE_LO_BIT];
                    nxt_idx = 4'h0;
                    nxt_entries = 6'h00;
                    nxt_pend = 1'b0;
                    nxt_io_seen = 1'b0;
                    nxt_mem_seen = 1'b0;
                    nxt_err = 1'b0;
                    if (eff_word[MODE_HI_BIT:MODE_LO_BIT] == 2'b00)
                        nxt_state = ST_MANUAL;
                    else
                        nxt_state = ST_GEN;
                end
            end
            ST_GEN:
            begin
                if (buf_in_ready)
                begin
                    nxt_idx = idx_ff + 4'h1;
                    if ({1'b0, idx_ff} == node_count - 5'h01)
                        nxt_state = ST_RUN;
                end
            end
            ST_MANUAL:
            begin
                if (pend_ff && buf_in_ready)
                begin
                    nxt_pend = 1'b0;
                    if (pend_last_ff)
                        nxt_state = ST_RUN;
                end
                if (table_valid && tready_ff)
                begin
                    if (bad_entry)
                    begin
                        nxt_state = ST_ERROR;
                        nxt_err = 1'b1;
                    end
                    else
                    begin
                        nxt_pend = 1'b1;
                        nxt_pend_last = table_last;
                        nxt_pend_entry = {table_node, table_io_start, table_io_send,
                            table_io_recv, table_mem_start, table_mem_send, table_mem_recv};
                        nxt_entries = entries_ff + 6'h01;
                        nxt_bwr = 1'b1;
                        nxt_bidx = entries_ff;
                        nxt_bentry = nxt_pend_entry;
                        if (table_io_send != 8'h00)
                        begin
                            nxt_io_seen = 1'b1;
                            nxt_io_exp = table_io_start + 16'(table_io_send);
                        end
                        if (table_mem_send != 8'h00)
                        begin
                            nxt_mem_seen = 1'b1;
                            nxt_mem_exp = table_mem_start + 16'(table_mem_send);
                        end
                    end
                end
            end
        endcase
        if (!start_bit)
            nxt_state = ST_IDLE;
        nxt_run = (nxt_state == ST_RUN);
        nxt_tready = (nxt_state == ST_MANUAL) && !nxt_pend;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            state_ff <= ST_IDLE;
            mode_ff <= MODE_MANUAL;
            size_ff <= 2'b00;
            idx_ff <= 4'h0;
            entries_ff <= 6'h00;
            pend_ff <= 1'b0;
            pend_last_ff <= 1'b0;
            pend_entry_ff <= '0;
            io_seen_ff <= 1'b0;
            mem_seen_ff <= 1'b0;
            io_exp_ff <= 16'h0000;
            mem_exp_ff <= 16'h0000;
            tready_ff <= 1'b0;
            bwr_ff <= 1'b0;
            bidx_ff <= 6'h00;
            bentry_ff <= '0;
            run_ff <= 1'b0;
            err_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            mode_ff <= nxt_mode;
            size_ff <= nxt_size;
            idx_ff <= nxt_idx;
            entries_ff <= nxt_entries;
            pend_ff <= nxt_pend;
            pend_last_ff <= nxt_pend_last;
            pend_entry_ff <= nxt_pend_entry;
            io_seen_ff <= nxt_io_seen;
            mem_seen_ff <= nxt_mem_seen;
            io_exp_ff <= nxt_io_exp;
            mem_exp_ff <= nxt_mem_exp;
            tready_ff <= nxt_tready;
            bwr_ff <= nxt_bwr;
            bidx_ff <= nxt_bidx;
            bentry_ff <= nxt_bentry;
            run_ff <= nxt_run;
            err_ff <= nxt_err;
        end
    end

    // legacy address map, one cycle of latency
    always_comb
    begin
        nxt_map_v = legacy_valid;
        nxt_map_mem = !legacy_relay;
        nxt_map_word = map_word_ff;
        nxt_map_err = 1'b0;
        if (legacy_valid)
        begin
            if (legacy_relay)
            begin
                nxt_map_word = CORE_IO_BASE + 16'(legacy_word);
                nxt_map_err = legacy_word > LEGACY_RELAY_LAST;
            end
            else
            begin
                nxt_map_word = PARAM_MEM_BASE + 16'(legacy_word);
                nxt_map_err = legacy_word > LEGACY_MEM_LAST;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            map_v_ff <= 1'b0;
            map_mem_ff <= 1'b0;
            map_word_ff <= 16'h0000;
            map_err_ff <= 1'b0;
        end
        else
        begin
            map_v_ff <= nxt_map_v;
            map_mem_ff <= nxt_map_mem;
            map_word_ff <= nxt_map_word;
            map_err_ff <= nxt_map_err;
        end
    end

    assign setup_rdata = rdata_ff;
    assign links_running = run_ff;
    assign config_error = err_ff;
    assign active_mode = mode_ff;
    assign table_ready = tready_ff;
    assign backup_wr = bwr_ff;
    assign backup_index = bidx_ff;
    assign backup_entry = bentry_ff;
    assign mapped_valid = map_v_ff;
    assign mapped_mem = map_mem_ff;
    assign mapped_word = map_word_ff;
    assign mapped_error = map_err_ff;
endmodule : link_area_config_allocator
`default_nettype wire

// ### logic/two_entry_buffer.sv
// two-entry valid/ready buffer with registered head
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic head_v_ff;
    logic spare_v_ff;
    logic [WIDTH-1:0] head_ff;
    logic [WIDTH-1:0] spare_ff;
    logic nxt_head_v;
    logic nxt_spare_v;
    logic [WIDTH-1:0] nxt_head;
    logic [WIDTH-1:0] nxt_spare;
    logic push;
    logic pop;

    // full only when both slots hold a word
    assign in_ready = !spare_v_ff;
    assign out_valid = head_v_ff;
    assign out_data = head_ff;

    always_comb
    begin
        push = in_valid && in_ready;
        pop = head_v_ff && out_ready;
        nxt_head_v = head_v_ff;
        nxt_spare_v = spare_v_ff;
        nxt_head = head_ff;
        nxt_spare = spare_ff;
        if (!head_v_ff || pop)
        begin
            if (spare_v_ff)
            begin
                nxt_head = spare_ff;
                nxt_head_v = 1'b1;
                nxt_spare_v = 1'b0;
            end
            else
            begin
                nxt_head = in_data;
                nxt_head_v = push;
            end
        end
        else if (push)
        begin
            nxt_spare = in_data;
            nxt_spare_v = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            head_v_ff <= 1'b0;
            spare_v_ff <= 1'b0;
            head_ff <= '0;
            spare_ff <= '0;
        end
        else
        begin
            head_v_ff <= nxt_head_v;
            spare_v_ff <= nxt_spare_v;
            head_ff <= nxt_head;
            spare_ff <= nxt_spare;
        end
    end
endmodule : two_entry_buffer
`default_nettype wire
